// file: stb_pkg.sv
// Package with constants, types and the overview of the sequence timer bank
//--------------------------------------------------------------------------
// Overview of operation
// - Eight independent channels, each selected by index.
// - 31-bit up counter, one count per 10 ms.
// - Program start puts every channel free running.
// - Start or delay commands clear and restart counting.
// - Contact mode stops and holds on preset match.
// - Stop clears, restarts, returns to free running.
// - Start loads preset, clears count, contact low.
// - Match sets contact once, then counting stops.
// - Commands never stall the issuing interpreter.
// - Stop leaves the contact value untouched.
// - Delay commands drive target on or off.
// - Count and contact readable at any time.
//--------------------------------------------------------------------------
package stb_pkg;
    localparam int STB_CHANNELS = 8;
    localparam int STB_IDX_W = 3;
    localparam int STB_COUNT_W = 31;
    localparam int STB_CLK_HZ = 25000000;
    localparam int STB_TICK_MS = 10;
    localparam int STB_TICK_CYCLES = STB_CLK_HZ / 1000 * STB_TICK_MS;
    localparam int STB_PRE_W = 18;
    localparam logic [STB_COUNT_W-1:0] STB_COUNT_RST = 31'h00000000;
    localparam logic [STB_COUNT_W-1:0] STB_PRESET_RST = 31'h00000000;
    // Command codes
    typedef enum logic [2:0] {
        STB_CMD_NONE = 3'h0,
        STB_CMD_SET = 3'h1,
        STB_CMD_DLY_ON = 3'h2,
        STB_CMD_DLY_OFF = 3'h3,
        STB_CMD_STOP = 3'h4
    } stb_cmd_t;
    // Channel modes, one-hot
    typedef enum logic [2:0] {
        STB_MODE_FREE = 3'h1,
        STB_MODE_RUN = 3'h2,
        STB_MODE_DONE = 3'h4
    } stb_mode_t;
endpackage

// file: stb_tick_if.sv
// Interface carrying the shared 10 ms tick and program start pulse
`timescale 1ns/1ps
interface stb_tick_if;
    logic tick;
    logic prog_start;
    modport src (output tick, output prog_start);
    modport dst (input tick, input prog_start);
endinterface

// file: stb_tick_gen.sv
// Time base that produces one tick every 10 ms
`timescale 1ns/1ps
module stb_tick_gen
    import stb_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic start_in,
    stb_tick_if.src tb
);
    logic [STB_PRE_W-1:0] div_r;
    logic tick_r;

    // Divider restarts with the program so the first tick is a full period
    always_ff @(posedge clk)
    begin
        if (!rstn || start_in)
        begin
            div_r <= '0;
            tick_r <= 1'b0;
        end
        else if (div_r == STB_PRE_W'(STB_TICK_CYCLES - 1))
        begin
            div_r <= '0;
            tick_r <= 1'b1;
        end
        else
        begin
            div_r <= div_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    // Program start passes straight on so it beats a command on the same edge
    assign tb.tick = tick_r;
    assign tb.prog_start = start_in;
endmodule

// file: stb_timer_bank.sv
// Eight channel sequence timer bank with counters, presets and contacts
`timescale 1ns/1ps
module stb_timer_bank
    import stb_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic PROG_START,
    input wire logic CMD_VALID,
    input wire logic [2:0] CMD_OP,
    input wire logic [STB_IDX_W-1:0] CMD_CHAN,
    input wire logic [STB_COUNT_W-1:0] CMD_PRESET,
    output logic CMD_READY,
    input wire logic [STB_IDX_W-1:0] RD_CHAN,
    output logic [STB_COUNT_W-1:0] RD_CHAN_COUNT,
    output logic RD_CHAN_CONTACT,
    output logic [STB_CHANNELS-1:0] CHAN_CONTACT,
    output logic [STB_CHANNELS-1:0] TARGET_SET,
    output logic [STB_CHANNELS-1:0] TARGET_CLR
);
    //----------------------------------------------------------------------
    // Time base
    //----------------------------------------------------------------------
    stb_tick_if tb_if ();

    stb_tick_gen u_tick
    (
        .clk(CLK),
        .rstn(RSTN),
        .start_in(PROG_START),
        .tb(tb_if.src)
    );

    //----------------------------------------------------------------------
    // Command acceptance
    //----------------------------------------------------------------------
    // Commands are taken every cycle, interpreter never waits
    assign CMD_READY = 1'b1;

    //----------------------------------------------------------------------
    // Channels
    //----------------------------------------------------------------------
    // Per channel state, one entry or bit per channel
    logic [STB_COUNT_W-1:0] count_r [STB_CHANNELS];
    logic [STB_COUNT_W-1:0] preset_r [STB_CHANNELS];
    stb_mode_t mode_r [STB_CHANNELS];
    logic [STB_CHANNELS-1:0] contact_r;
    logic [STB_CHANNELS-1:0] dly_on_r;
    logic [STB_CHANNELS-1:0] dly_armed_r;
    logic [STB_CHANNELS-1:0] tset_r;
    logic [STB_CHANNELS-1:0] tclr_r;

    genvar g;
    generate
        for (g = 0; g < STB_CHANNELS; g++)
        begin : g_chan
            logic hit;
            logic is_delay;
            logic is_load;
            logic is_stop;
            logic match;
            logic fire;

            //--------------------------------------------------------------
            // Command decode
            //--------------------------------------------------------------
            // Decode of a command aimed at this channel; codes 0 and 5 to 7 do nothing
            assign hit = CMD_VALID && (CMD_CHAN == STB_IDX_W'(g));
            assign is_delay = hit && (CMD_OP == STB_CMD_DLY_ON || CMD_OP == STB_CMD_DLY_OFF);
            assign is_load = is_delay || (hit && CMD_OP == STB_CMD_SET);
            assign is_stop = hit && (CMD_OP == STB_CMD_STOP);

            //--------------------------------------------------------------
            // Match and firing
            //--------------------------------------------------------------
            // Preset comparison is live only while counting to a preset
            assign match = (mode_r[g] == STB_MODE_RUN) && (count_r[g] == preset_r[g]);
            // A reload or program start on the match edge swallows the firing
            assign fire = match && !is_load && !tb_if.prog_start;

            //--------------------------------------------------------------
            // Preset buffer
            //--------------------------------------------------------------
            // Preset buffer loaded by start and delay commands
            always_ff @(posedge CLK)
            begin
                if (!RSTN)
                    preset_r[g] <= STB_PRESET_RST;
                else if (is_load)
                    preset_r[g] <= CMD_PRESET;
            end

            //--------------------------------------------------------------
            // Counter and mode
            //--------------------------------------------------------------
            // Counter advances on ticks; contact mode halts it at the preset
            always_ff @(posedge CLK)
            begin
                if (!RSTN)
                begin
                    count_r[g] <= STB_COUNT_RST;
                    mode_r[g] <= STB_MODE_FREE;
                end
                else if (tb_if.prog_start)
                begin
                    count_r[g] <= STB_COUNT_RST;
                    mode_r[g] <= STB_MODE_FREE;
                end
                else if (is_load)
                begin
                    count_r[g] <= STB_COUNT_RST;
                    mode_r[g] <= STB_MODE_RUN;
                end
                else if (is_stop)
                begin
                    count_r[g] <= STB_COUNT_RST;
                    mode_r[g] <= STB_MODE_FREE;
                end
                else
                begin
                    case (mode_r[g])
                        STB_MODE_FREE:
                        begin
                            if (tb_if.tick)
                                count_r[g] <= count_r[g] + 1'b1;
                        end
                        STB_MODE_RUN:
                        begin
                            if (match)
                                mode_r[g] <= STB_MODE_DONE;
                            else if (tb_if.tick)
                                count_r[g] <= count_r[g] + 1'b1;
                        end
                        STB_MODE_DONE:
                            count_r[g] <= count_r[g];
                        default:
                            mode_r[g] <= STB_MODE_FREE;
                    endcase
                end
            end

            //--------------------------------------------------------------
            // Contact
            //--------------------------------------------------------------
            // Contact: cleared on load, set once on match, kept by stop
            always_ff @(posedge CLK)
            begin
                if (!RSTN || tb_if.prog_start)
                    contact_r[g] <= 1'b0;
                else if (is_load)
                    contact_r[g] <= 1'b0;
                else if (match)
                    contact_r[g] <= 1'b1;
                // Stop command leaves the contact alone
            end

            //--------------------------------------------------------------
            // Delay targets
            //--------------------------------------------------------------
            // Delay target arming and polarity
            always_ff @(posedge CLK)
            begin
                if (!RSTN || tb_if.prog_start)
                begin
                    dly_armed_r[g] <= 1'b0;
                    dly_on_r[g] <= 1'b0;
                end
                else if (is_load)
                begin
                    dly_armed_r[g] <= is_delay;
                    dly_on_r[g] <= (CMD_OP == STB_CMD_DLY_ON);
                end
                else if (match || is_stop)
                    dly_armed_r[g] <= 1'b0;
            end

            //--------------------------------------------------------------
            // Target pulses
            //--------------------------------------------------------------
            // One-cycle target pulses when a delay fires; a stop on that edge is too late
            always_ff @(posedge CLK)
            begin
                if (!RSTN)
                begin
                    tset_r[g] <= 1'b0;
                    tclr_r[g] <= 1'b0;
                end
                else
                begin
                    tset_r[g] <= fire && dly_armed_r[g] && dly_on_r[g];
                    tclr_r[g] <= fire && dly_armed_r[g] && !dly_on_r[g];
                end
            end
        end
    endgenerate

    //----------------------------------------------------------------------
    // Read back
    //----------------------------------------------------------------------
    // Selected channel count, one cycle behind the select
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            RD_CHAN_COUNT <= STB_COUNT_RST;
        else
            RD_CHAN_COUNT <= count_r[RD_CHAN];
    end

    // Selected channel contact, aligned with the count above
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            RD_CHAN_CONTACT <= 1'b0;
        else
            RD_CHAN_CONTACT <= contact_r[RD_CHAN];
    end

    //----------------------------------------------------------------------
    // Outputs
    //----------------------------------------------------------------------
    // Contact levels and target pulses straight from their flip-flops
    assign CHAN_CONTACT = contact_r;
    assign TARGET_SET = tset_r;
    assign TARGET_CLR = tclr_r;
endmodule

// file: stb_monitor.sv
// Port checker for the sequence timer bank
`timescale 1ns/1ps
module stb_monitor
    import stb_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic PROG_START,
    input wire logic CMD_VALID,
    input wire logic [2:0] CMD_OP,
    input wire logic [STB_IDX_W-1:0] CMD_CHAN,
    input wire logic CMD_READY,
    input wire logic [STB_IDX_W-1:0] RD_CHAN,
    input wire logic RD_CHAN_CONTACT,
    input wire logic [STB_CHANNELS-1:0] CHAN_CONTACT,
    input wire logic [STB_CHANNELS-1:0] TARGET_SET,
    input wire logic [STB_CHANNELS-1:0] TARGET_CLR
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RSTN);
    logic [STB_CHANNELS-1:0] cont_r;
    // Contacts as seen one cycle earlier
    always_ff @(posedge CLK)
        cont_r <= RSTN ? CHAN_CONTACT : '0;
    // Load and stop steps of a command
    sequence s_load;
        CMD_VALID && !PROG_START && CMD_OP inside {3'h1, 3'h2, 3'h3};
    endsequence
    sequence s_stop_on;
        CMD_VALID && !PROG_START && CMD_OP == 3'h4 && CHAN_CONTACT[CMD_CHAN];
    endsequence
    AST_READY: assert property (CMD_READY)
        else $error("command ready dropped");
    AST_LOAD_CLR: assert property (s_load |=> !CHAN_CONTACT[$past(CMD_CHAN)])
        else $error("load left contact set");
    AST_STOP_KEEP: assert property (s_stop_on |=> CHAN_CONTACT[$past(CMD_CHAN)])
        else $error("stop changed contact");
    AST_PROG_CLR: assert property (PROG_START |=> CHAN_CONTACT == '0)
        else $error("program start kept a contact");
    AST_TGT_EXCL: assert property ((TARGET_SET & TARGET_CLR) == '0)
        else $error("target set and clear together");
    AST_TGT_PULSE: assert property (|TARGET_SET |=> (TARGET_SET & $past(TARGET_SET)) == '0)
        else $error("target pulse too long");
    AST_TGT_CONT: assert property (((TARGET_SET | TARGET_CLR) & ~CHAN_CONTACT) == '0)
        else $error("target pulse without contact");
    AST_RD_CONT: assert property (RD_CHAN_CONTACT == cont_r[$past(RD_CHAN)])
        else $error("read contact differs");
endmodule
bind stb_timer_bank stb_monitor stb_monitor_inst (.CLK(CLK), .RSTN(RSTN),
    .PROG_START(PROG_START), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .CMD_CHAN(CMD_CHAN),
    .CMD_READY(CMD_READY), .RD_CHAN(RD_CHAN), .RD_CHAN_CONTACT(RD_CHAN_CONTACT),
    .CHAN_CONTACT(CHAN_CONTACT), .TARGET_SET(TARGET_SET), .TARGET_CLR(TARGET_CLR));

// file: stb_interp_model.sv
// Behavioural interpreter that issues timer commands
`timescale 1ns/1ps
module stb_interp_model
    import stb_pkg::*;
(
    input wire logic clk,
    output logic prog_start,
    output logic cmd_valid,
    output logic [2:0] cmd_op,
    output logic [STB_IDX_W-1:0] cmd_chan,
    output logic [STB_COUNT_W-1:0] cmd_preset
);
    initial
    begin
        prog_start = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 3'h0;
        cmd_chan = 3'h0;
        cmd_preset = 31'h0;
    end
    // One cycle program start pulse
    task automatic start_program();
        prog_start = 1'b1;
        @(negedge clk);
        prog_start = 1'b0;
    endtask
    // One command per edge, never waiting for ready
    task automatic issue(input logic [2:0] op, input logic [2:0] ch, input logic [30:0] ticks);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_chan = ch;
        cmd_preset = ticks; // Already in 10 ms ticks
        @(negedge clk);
    endtask
    // Strobe low; idle lines show a changing pattern
    task automatic idle();
        cmd_valid = 1'b0;
        cmd_op = ~cmd_op;
        cmd_preset = ~cmd_preset;
    endtask
endmodule

// file: tb_top.sv
// Self-checking testbench for the sequence timer bank
`timescale 1ns/1ps
module tb_top;
    import stb_pkg::*;
    logic CLK = 1'b0;
    logic RSTN = 1'b0;
    logic [2:0] rd_chan = 3'h0;
    logic prog_start, cmd_valid, cmd_ready, rd_contact;
    logic [2:0] cmd_op, cmd_chan;
    logic [30:0] cmd_preset, rd_count;
    logic [7:0] contact, tset, tclr;
    logic [7:0] set_seen = 8'h00;
    logic [7:0] clr_seen = 8'h00;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    int seed = 32'hef686b9a;
    int k, n, op;
    always #20 CLK = ~CLK;
    stb_interp_model stb_interp_model_inst (.clk(CLK), .prog_start(prog_start),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_chan(cmd_chan), .cmd_preset(cmd_preset));
    stb_timer_bank stb_timer_bank_inst (.CLK(CLK), .RSTN(RSTN), .PROG_START(prog_start),
        .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_CHAN(cmd_chan), .CMD_PRESET(cmd_preset),
        .CMD_READY(cmd_ready), .RD_CHAN(rd_chan), .RD_CHAN_COUNT(rd_count),
        .RD_CHAN_CONTACT(rd_contact), .CHAN_CONTACT(contact), .TARGET_SET(tset),
        .TARGET_CLR(tclr));
    // Sticky pulse capture and hang limit
    always @(posedge CLK)
    begin
        set_seen <= set_seen | tset;
        clr_seen <= clr_seen | tclr;
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            bad_count = bad_count + 1;
            final_report();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic read_chan(input int c);
        rd_chan = c[2:0];
        @(negedge CLK);
        @(negedge CLK);
    endtask
    // Expected {set, clear} target pulses of a load command
    function automatic logic [1:0] exp_pulse(input int c);
        return {c == 2, c == 3};
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (20) @(negedge CLK);
        RSTN = 1'b1;
        for (k = 0; k < 8; k++)
        begin
            read_chan(k);
            check({rd_contact, rd_count}, 0);
        end
        $display("test reset done");
        stb_interp_model_inst.start_program();
        for (k = 0; k < 8; k++)
        begin
            op = 1 + k % 3;
            stb_interp_model_inst.issue(op[2:0], k[2:0], 31'h0);
            check(cmd_ready, 1);
            stb_interp_model_inst.idle();
            check(contact[k], 0);
            n = 0;
            while (contact[k] !== 1'b1 && n < 8)
            begin
                @(negedge CLK);
                n++;
            end
            repeat (4) @(negedge CLK);
            check({set_seen[k], clr_seen[k]}, exp_pulse(op));
            read_chan(k);
            check({rd_contact, rd_count}, 32'h80000000);
        end
        $display("test zero preset done");
        stb_interp_model_inst.issue(3'h4, 3'h0, 31'h5);
        for (k = 5; k < 8; k++)
            stb_interp_model_inst.issue(k[2:0], 3'h1, 31'h0);
        stb_interp_model_inst.idle();
        read_chan(0);
        check({rd_contact, rd_count}, 32'h80000000);
        check(contact, 8'hFF);
        $display("test stop done");
        for (k = 0; k < 8; k++)
        begin
            op = 1 + $unsigned($random(seed)) % 3;
            stb_interp_model_inst.issue(op[2:0], k[2:0], 31'($random(seed) | 1));
        end
        stb_interp_model_inst.idle();
        repeat (50) @(negedge CLK);
        check(contact, 8'h00);
        read_chan($random(seed) & 7);
        check({rd_contact, rd_count}, 0);
        $display("test reload done");
        stb_interp_model_inst.issue(3'h1, 3'h2, 31'h0);
        stb_interp_model_inst.idle();
        repeat (5) @(negedge CLK);
        stb_interp_model_inst.start_program();
        check(contact, 8'h00);
        $display("test program start done");
        final_report();
    end
endmodule
